// ### include/gp_pkg.sv
// Package: register map, reset values and sensitivity codes of the GPIO port
package gp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] GP_ADDR_DATA = 2'h0;
    localparam logic [1:0] GP_ADDR_DIR = 2'h1;
    localparam logic [1:0] GP_ADDR_OPT = 2'h2;
    localparam logic [1:0] GP_ADDR_STAT = 2'h3;
    localparam int GP_ADDR_W = 2;
    localparam int GP_PINS = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GP_DATA_RST = 8'h00;
    localparam logic [7:0] GP_DIR_RST = 8'h00;
    localparam logic [7:0] GP_OPT_RST = 8'h00;

    // ------------------------------------------------------------
    // Sensitivity encoding of each interrupt group
    // ------------------------------------------------------------
    localparam logic [1:0] GP_SENS_FALL_LOW = 2'h0;
    localparam logic [1:0] GP_SENS_RISE = 2'h1;
    localparam logic [1:0] GP_SENS_FALL = 2'h2;
    localparam logic [1:0] GP_SENS_BOTH = 2'h3;

endpackage : gp_pkg

// ### rtl/gp_port.sv
// Eight pin bidirectional GPIO port with external interrupt request latch
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps

module gp_port
    import gp_pkg::*;
#(
    parameter int PINS = gp_pkg::GP_PINS,
    parameter int GROUPS = 2,
    parameter logic [PINS*2-1:0] GROUP_MAP = 16'h5500  // Pin to vector group, two bits each
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [gp_pkg::GP_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pads
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pullup_en,
    // Alternate functions
    input wire logic [PINS-1:0] alt_out_en,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] alt_open_drain,
    input wire logic [PINS-1:0] alt_in_en,
    output logic [PINS-1:0] alt_in,
    // Interrupt side
    input wire logic [PINS-1:0] irq_capable,
    input wire logic [GROUPS*2-1:0] ext_irq_sensitivity_reg,
    input wire logic cpu_irq_masked,
    input wire logic [GROUPS-1:0] irq_vector_fetch,
    output logic [GROUPS-1:0] ext_irq_req
);
    import gp_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Edge or level qualification for one pin
    // Level-low hits again every cycle; edges compare with the last sample
    function automatic logic sense_hit(input logic [1:0] sens, input logic prev,
                                       input logic cur);
        logic hit;
        hit = 1'b0;
        case (sens)
            GP_SENS_FALL_LOW: hit = !cur;
            GP_SENS_RISE: hit = cur && !prev;
            GP_SENS_FALL: hit = !cur && prev;
            GP_SENS_BOTH: hit = cur ^ prev;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : sense_hit

    // Vector group of one pin; a field beyond the group count joins none
    function automatic logic [1:0] group_of(input int pin);
        return GROUP_MAP[pin*2 +: 2];
    endfunction : group_of

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    // Software-visible registers and their next values
    logic [PINS-1:0] pin_data_latch;
    logic [PINS-1:0] pin_direction;
    logic [PINS-1:0] pin_option;
    logic [PINS-1:0] next_pin_data_latch;
    logic [PINS-1:0] next_pin_direction;
    logic [PINS-1:0] next_pin_option;
    logic [7:0] next_reg_rdata;

    // ------------------------------------------------------------
    // Pin mode decode
    // ------------------------------------------------------------
    // Effective direction, value and drive kind after peripheral takeover
    logic [PINS-1:0] drive_hi;
    logic [PINS-1:0] eff_out;
    logic [PINS-1:0] eff_val;
    logic [PINS-1:0] eff_od;
    logic [PINS-1:0] irq_pin_en;
    logic [PINS-1:0] pin_view;

    // Alternate output wins over register programming
    // Registers only steer a pin while no peripheral output owns it
    always_comb
    begin
        eff_out = pin_direction | alt_out_en;
        eff_val = '0;
        eff_od = '0;
        // Peripheral output supplies value and drive kind when it owns the pin
        for (int i = 0; i < PINS; i++)
        begin
            eff_val[i] = alt_out_en[i] ? alt_out[i] : pin_data_latch[i];
            eff_od[i] = alt_out_en[i] ? alt_open_drain[i] : !pin_option[i];
        end
        // Open-drain only ever pulls low; push-pull drives both levels
        drive_hi = eff_out & eff_val & ~eff_od;
        // Interrupt-capable input pins with option set, and no alternate function active
        irq_pin_en = ~eff_out & pin_option & irq_capable & ~alt_in_en;
        // Readback: latch for outputs, alt value for alt-driven inputs, else pin
        for (int i = 0; i < PINS; i++)
        begin
            if (pin_direction[i])
                pin_view[i] = pin_data_latch[i];
            else if (alt_out_en[i])
                pin_view[i] = alt_out[i];
            else
                pin_view[i] = pad_in[i];
        end
    end

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    // Request latch, kept off every readable index
    logic [GROUPS-1:0] ext_irq_req_q;

    // Write decode and one-cycle-late read data
    // Index 3 has no storage: a write there falls into the default arm
    always_comb
    begin
        next_pin_data_latch = pin_data_latch;
        next_pin_direction = pin_direction;
        next_pin_option = pin_option;
        next_reg_rdata = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                GP_ADDR_DATA: next_pin_data_latch = reg_wdata[PINS-1:0];
                GP_ADDR_DIR: next_pin_direction = reg_wdata[PINS-1:0];
                GP_ADDR_OPT: next_pin_option = reg_wdata[PINS-1:0];
                default: ;
            endcase
        end
        // Read data captured now, shown for one cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                GP_ADDR_DATA: next_reg_rdata[PINS-1:0] = pin_view;
                GP_ADDR_DIR: next_reg_rdata[PINS-1:0] = pin_direction;
                GP_ADDR_OPT: next_reg_rdata[PINS-1:0] = pin_option;
                // Status shows effective directions (eff_out), not pad enables; request latch is hidden
                GP_ADDR_STAT: next_reg_rdata[PINS-1:0] = eff_out;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    // Register file storage
    // Reset leaves every pin a floating input with its latch cleared
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_data_latch <= GP_DATA_RST[PINS-1:0];
            pin_direction <= GP_DIR_RST[PINS-1:0];
            pin_option <= GP_OPT_RST[PINS-1:0];
            reg_rdata <= 8'h00;
        end
        else
        begin
            pin_data_latch <= next_pin_data_latch;
            pin_direction <= next_pin_direction;
            pin_option <= next_pin_option;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // Pad and alternate input outputs
    // ------------------------------------------------------------
    // Next values of the registered pad controls
    logic [PINS-1:0] next_pad_out;
    logic [PINS-1:0] next_pad_oe;
    logic [PINS-1:0] next_pad_pullup_en;
    logic [PINS-1:0] next_alt_in;

    // Pads registered so every output leaves a flip-flop; one cycle of latency
    // buys glitch-free pad controls when several registers change together
    always_comb
    begin
        next_pad_out = eff_val;
        // Enable to drive high, or to pull low in either drive kind
        next_pad_oe = drive_hi | (eff_out & ~eff_val);
        next_pad_pullup_en = ~eff_out & pin_option;
        // Peripheral sees the latch when the pin is a plain output
        next_alt_in = '0;
        for (int i = 0; i < PINS; i++)
            next_alt_in[i] = (pin_direction[i] && !alt_out_en[i])
                             ? pin_data_latch[i] : pad_in[i];
    end

    // Pad state holds through wait and halt: no low-power input exists here
    // Reset drops every enable, so pins float until software or a peripheral output (alt_out_en) drives them
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pullup_en <= '0;
            alt_in <= '0;
        end
        else
        begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            pad_pullup_en <= next_pad_pullup_en;
            alt_in <= next_alt_in;
        end
    end

    // ------------------------------------------------------------
    // External interrupt detection
    // ------------------------------------------------------------
    // Edge detector history, sensitivity copy and request next values
    logic [PINS-1:0] pin_prev;
    logic [PINS-1:0] next_pin_prev;
    logic [GROUPS*2-1:0] sens_prev;
    logic [GROUPS-1:0] next_ext_irq_req_q;
    logic [GROUPS-1:0] grp_hit;

    // Detect per pin, OR per group, latch until fetch or sensitivity edit
    // Limitation: in level-low mode an unmasked fetch does not clear at all while
    // the pin stays low; software must release the pin or change the code
    always_comb
    begin
        next_pin_prev = pad_in;
        grp_hit = '0;
        // Each pin votes into its own group only
        for (int i = 0; i < PINS; i++)
        begin
            for (int g = 0; g < GROUPS; g++)
            begin
                if (group_of(i) == 2'(g) && irq_pin_en[i]
                    && sense_hit(ext_irq_sensitivity_reg[g*2 +: 2], pin_prev[i], pad_in[i]))
                    grp_hit[g] = 1'b1;
            end
        end
        // Clear first, then let a fresh hit set again
        for (int g = 0; g < GROUPS; g++)
        begin
            next_ext_irq_req_q[g] = ext_irq_req_q[g];
            if (irq_vector_fetch[g]
                || ext_irq_sensitivity_reg[g*2 +: 2] != sens_prev[g*2 +: 2])
                next_ext_irq_req_q[g] = 1'b0;
            // A new event in the clearing cycle still sets the latch
            if (grp_hit[g] && !cpu_irq_masked)
                next_ext_irq_req_q[g] = 1'b1;
        end
    end

    // Interrupt state; request output mirrors the latch
    // Previous pad levels feed edge detection; the code copy spots edits
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pin_prev <= '0;
            sens_prev <= '0;
            ext_irq_req_q <= '0;
            ext_irq_req <= '0;
        end
        else
        begin
            pin_prev <= next_pin_prev;
            sens_prev <= ext_irq_sensitivity_reg;
            ext_irq_req_q <= next_ext_irq_req_q;
            ext_irq_req <= next_ext_irq_req_q;
        end
    end

endmodule : gp_port

// ### test/gp_checker.sv
// Checker: port-level assertions of the GPIO port
`timescale 1ns/1ps
module gp_checker
    import gp_pkg::*;
#(
    parameter int PINS = 8,
    parameter int GROUPS = 2
)
(
    // Clock, reset, register port
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [GP_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pads and peripherals
    input wire logic [PINS-1:0] pad_in,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pad_pullup_en,
    input wire logic [PINS-1:0] alt_out_en,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] alt_open_drain,
    input wire logic [PINS-1:0] alt_in_en,
    input wire logic [PINS-1:0] alt_in,
    // Interrupt side
    input wire logic [GROUPS*2-1:0] ext_irq_sensitivity_reg,
    input wire logic cpu_irq_masked,
    input wire logic [GROUPS-1:0] irq_vector_fetch,
    input wire logic [GROUPS-1:0] ext_irq_req
);
    logic [7:0] dat, dir, opt, next_dat, next_dir, next_opt;
    logic [7:0] e_oe, e_out, e_pu, e_ain, e_rd;
    // ----------------
    // Shadow registers
    // ----------------
    always_comb
    begin
        next_dat = (reg_wr && reg_addr == GP_ADDR_DATA) ? reg_wdata : dat;
        next_dir = (reg_wr && reg_addr == GP_ADDR_DIR) ? reg_wdata : dir;
        next_opt = (reg_wr && reg_addr == GP_ADDR_OPT) ? reg_wdata : opt;
    end
    always_ff @(posedge ref_clk)
    begin
        dat <= rst_n ? next_dat : GP_DATA_RST;
        dir <= rst_n ? next_dir : GP_DIR_RST;
        opt <= rst_n ? next_opt : GP_OPT_RST;
    end
    // Expected views; a peripheral output overrides the registers, except in readback of pins with the direction bit set
    always_comb
    begin
        e_oe = (alt_out_en & (~alt_open_drain | ~alt_out)) | (~alt_out_en & dir & (opt | ~dat));
        e_out = (alt_out_en & alt_out) | (~alt_out_en & dat);
        e_pu = ~dir & opt & ~alt_out_en;
        e_ain = (dir & ~alt_out_en & dat) | (~(dir & ~alt_out_en) & pad_in);
        e_rd = (reg_addr == GP_ADDR_DIR) ? dir : (reg_addr == GP_ADDR_OPT) ? opt
            : (dir & dat) | (~dir & alt_out_en & alt_out) | (~dir & ~alt_out_en & pad_in);
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd; reg_rd && reg_addr != GP_ADDR_STAT |=> reg_rdata == $past(e_rd); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_oe; $past(rst_n) |-> pad_oe == $past(e_oe); endproperty
    a_oe: assert property (p_oe) else $error("pad enable wrong");
    property p_out; $past(rst_n) |-> (pad_out & pad_oe) == ($past(e_out) & pad_oe); endproperty
    a_out: assert property (p_out) else $error("pad value wrong");
    property p_pu; $past(rst_n) |-> pad_pullup_en == $past(e_pu); endproperty
    a_pu: assert property (p_pu) else $error("pull-up wrong");
    property p_ain; $past(rst_n) |-> (alt_in & $past(alt_in_en)) == ($past(e_ain) & $past(alt_in_en));
    endproperty
    a_ain: assert property (p_ain) else $error("peripheral input wrong");
    property p_mask; cpu_irq_masked |=> (ext_irq_req & ~$past(ext_irq_req)) == '0; endproperty
    a_mask: assert property (p_mask) else $error("request while masked");
    property p_fetch; cpu_irq_masked && irq_vector_fetch[0] |=> !ext_irq_req[0]; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch left request");
    property p_sens; cpu_irq_masked && $changed(ext_irq_sensitivity_reg[1:0]) |=> !ext_irq_req[0];
    endproperty
    a_sens: assert property (p_sens) else $error("code change left request");
endmodule : gp_checker

bind gp_port gp_checker #(.PINS(PINS), .GROUPS(GROUPS)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .alt_out_en(alt_out_en), .alt_out(alt_out),
    .alt_open_drain(alt_open_drain), .alt_in_en(alt_in_en), .alt_in(alt_in),
    .ext_irq_sensitivity_reg(ext_irq_sensitivity_reg), .cpu_irq_masked(cpu_irq_masked),
    .irq_vector_fetch(irq_vector_fetch), .ext_irq_req(ext_irq_req));

// ### test/gp_pin_model.sv
// Pin model: external drivers, pull-ups and floating pads
`timescale 1ns/1ps
module gp_pin_model
(
    // Clock and port pads
    input wire logic ref_clk,
    input wire logic [7:0] pad_out, pad_oe, pad_pullup_en,
    // Bench drivers
    input wire logic [7:0] ext_en, ext_val,
    output logic [7:0] pad_in
);
    logic [7:0] flt = 8'h5a;
    // Undriven pads wander so a stale level never reads back
    always @(posedge ref_clk)
        flt <= {flt[6:0], ~flt[7]};
    // Port drive wins, then bench, then pull-up, else floating
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & (pad_pullup_en | flt));
endmodule : gp_pin_model

// ### test/test_bidirectional_io_port.sv
// Testbench: register-level tests of the GPIO port
`timescale 1ns/1ps
module test_bidirectional_io_port;
    import gp_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mask = 1'b0;
    logic [1:0] reg_addr = 2'h0, fetch = 2'h0, ext_irq_req;
    logic [3:0] sens = 4'h6;
    logic [7:0] reg_wdata = 8'h00, ao_en = 8'h00, ao = 8'h00, ao_od = 8'h00, ai_en = 8'h00;
    logic [7:0] ext_en = 8'hff, ext_val = 8'ha5, reg_rdata, pad_in, pad_out, pad_oe, pu, alt_in;
    logic [7:0] cap = 8'hff;
    int error_cnt = 0;
    int samples_checked = 0;
    always #50 ref_clk = ~ref_clk;
    gp_port #(.PINS(8), .GROUPS(2), .GROUP_MAP(16'h5500)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pu), .alt_out_en(ao_en), .alt_out(ao), .alt_open_drain(ao_od),
        .alt_in_en(ai_en), .alt_in(alt_in), .irq_capable(cap), .ext_irq_sensitivity_reg(sens),
        .cpu_irq_masked(mask), .irq_vector_fetch(fetch), .ext_irq_req(ext_irq_req));
    gp_pin_model u_pins (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // -----------------
    // Bus and pin tasks
    // -----------------
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", e, reg_rdata);
    endtask : rd
    task pins(input logic [7:0] en, input logic [7:0] v);
        @(posedge ref_clk);
        ext_en <= en;
        ext_val <= v;
    endtask : pins
    task pulse(input logic [1:0] g);
        @(posedge ref_clk);
        fetch <= g;
        @(posedge ref_clk);
        fetch <= 2'h0;
    endtask : pulse
    task rq(input int n, input logic [7:0] e);
        cyc(n);
        chk("irq request", e, 8'(ext_irq_req));
    endtask : rq
    task stop_test;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Hang guard, far beyond the sequence length
    initial
    begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(GP_ADDR_DIR, GP_DIR_RST);
        rd(GP_ADDR_DATA, 8'ha5);
        $display("reset test done");
        wr(GP_ADDR_DATA, 8'h3c);
        wr(GP_ADDR_OPT, 8'hf0);
        pins(8'h0f, 8'ha5);
        cyc(2);
        chk("pad enable", 8'h00, pad_oe);
        chk("pull-up", 8'hf0, pu);
        rd(GP_ADDR_DATA, 8'hf5);
        $display("input test done");
        pins(8'h00, 8'h00);
        wr(GP_ADDR_OPT, 8'h0f);
        wr(GP_ADDR_DIR, 8'hff);
        wr(GP_ADDR_STAT, 8'h00);
        cyc(2);
        chk("pad enable", 8'hcf, pad_oe);
        chk("pad value", 8'h0c, pad_out & pad_oe);
        rd(GP_ADDR_DATA, 8'h3c);
        rd(GP_ADDR_DIR, 8'hff);
        rd(GP_ADDR_STAT, 8'hff);
        $display("output test done");
        // Peripheral takes pins 6 and 7, pin 7 open drain
        @(posedge ref_clk);
        ai_en <= 8'hff;
        ao_en <= 8'hc0;
        ao <= 8'h80;
        ao_od <= 8'h80;
        cyc(3);
        chk("peripheral input", 8'h3c, alt_in & 8'h7f);
        chk("pad enable", 8'h4f, pad_oe);
        wr(GP_ADDR_DIR, 8'h00);
        pins(8'h3f, 8'h05);
        cyc(2);
        rd(GP_ADDR_DATA, 8'h85);
        rd(GP_ADDR_STAT, 8'hc0);
        @(posedge ref_clk);
        ao_en <= 8'h00;
        ai_en <= 8'h00;
        $display("alternate test done");
        pins(8'hff, 8'hff);
        wr(GP_ADDR_OPT, 8'hff);
        @(posedge ref_clk);
        mask <= 1'b1;
        pulse(2'h3);
        @(posedge ref_clk);
        mask <= 1'b0;
        rq(1, 8'h00);
        pins(8'hff, 8'hfe);
        rq(3, 8'h01);
        pulse(2'h1);
        rq(1, 8'h00);
        pins(8'hff, 8'hde);
        rq(3, 8'h00);
        pins(8'hff, 8'hfe);
        rq(3, 8'h02);
        @(posedge ref_clk);
        sens <= 4'he;
        rq(2, 8'h00);
        @(posedge ref_clk);
        mask <= 1'b1;
        pins(8'hff, 8'hfc);
        rq(3, 8'h00);
        @(posedge ref_clk);
        sens <= 4'hc;
        rq(2, 8'h00);
        @(posedge ref_clk);
        mask <= 1'b0;
        rq(3, 8'h01);
        pulse(2'h1);
        rq(1, 8'h01);
        pins(8'hff, 8'hff);
        pulse(2'h1);
        rq(1, 8'h00);
        pins(8'hff, 8'hef);
        rq(3, 8'h02);
        wr(GP_ADDR_OPT, 8'h00);
        pulse(2'h2);
        pins(8'hff, 8'hed);
        rq(3, 8'h00);
        // Pin 1 held low in level mode, first without interrupt capability
        @(posedge ref_clk);
        cap <= 8'hfd;
        wr(GP_ADDR_OPT, 8'h0f);
        rq(3, 8'h00);
        @(posedge ref_clk);
        cap <= 8'hff;
        rq(3, 8'h01);
        $display("interrupt test done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cyc(2);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(GP_ADDR_OPT, GP_OPT_RST);
        rd(GP_ADDR_DATA, 8'hed);
        $display("second reset test done");
        stop_test();
    end
endmodule : test_bidirectional_io_port
